// >>> logic/pkw_pkg.sv
// Constants for the port mode and key wake block
package pkw_pkg;
	localparam int PINS_PER_PORT = 8;
	localparam int KEY_PINS = 8;
	// Register byte offsets
	localparam logic [7:0] ADDR_LATCH = 8'h00;
	localparam logic [7:0] ADDR_MODE_A = 8'h04;
	localparam logic [7:0] ADDR_MODE_B = 8'h08;
	localparam logic [7:0] ADDR_OPTION = 8'h0c;
	localparam logic [7:0] ADDR_KEY_EN = 8'h10;
	localparam logic [7:0] ADDR_AUX = 8'h14;
	localparam logic [7:0] ADDR_PIN_IN = 8'h18;
	// port_option_reg fields
	localparam int OPT_SCHMITT_LSB = 0;
	localparam int OPT_TA_EN = 3;
	localparam int OPT_TB_EN = 4;
	localparam int OPT_CLK_EN = 5;
	localparam int OPT_WIDTH = 6;
	// aux_control_one fields
	localparam int AUX_FLAG = 0;
	localparam int AUX_IRQ_EN = 1;
	// Fixed pin indices (port * 8 + bit)
	localparam int PIN_OD_A = 10;
	localparam int PIN_OD_B = 11;
	localparam int PIN_RESET = 13;
	localparam int PIN_CLK_OUT = 16;
	// Timing in CPU clocks
	localparam logic [2:0] CLKS_PER_MC = 3'h4;
	localparam int STRONG_PU_CLKS = 2;
endpackage

// >>> logic/pkw_port_block.sv
// Port mode, pull-up staging, key wake and pin output routing
`timescale 1ns/1ps
module pkw_port_block
	import pkw_pkg::*;
#(
	parameter int N_PORTS = 3,
	parameter int TA_PIN = 2,
	parameter int TB_PIN = 3
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Boot options and timer events
	input wire logic i_reset_level_high,
	input wire logic i_reset_pin_disable,
	input wire logic i_osc_crystal,
	input wire logic i_timer_a_ovf,
	input wire logic i_timer_b_ovf,
	// Pin pads
	input wire logic [8*N_PORTS-1:0] i_pin_in,
	output logic [8*N_PORTS-1:0] o_pull_down,
	output logic [8*N_PORTS-1:0] o_strong_pu,
	output logic [8*N_PORTS-1:0] o_weak_pu,
	output logic [8*N_PORTS-1:0] o_vweak_pu,
	output logic [8*N_PORTS-1:0] o_schmitt,
	// Events
	output logic o_key_irq,
	output logic o_reset_pin_req
);
	localparam int NP = 8 * N_PORTS;

	if (N_PORTS != 3) begin : g_check
		$error("N_PORTS must be 3, option holds three Schmitt bits");
	end
	if (TA_PIN >= NP || TB_PIN >= NP) begin : g_check_tog
		$error("Toggle pin out of range");
	end

	logic [NP-1:0] latch;
	logic [NP-1:0] mode_a;
	logic [NP-1:0] mode_b;
	logic [OPT_WIDTH-1:0] option;
	logic [KEY_PINS-1:0] key_en;
	logic strap_done;
	logic key_event_flag;
	logic irq_en;
	logic tog_a;
	logic tog_b;
	logic [1:0] div_cnt;
	logic [NP-1:0] out_prev;
	logic [NP-1:0] strong_kick;
	logic [KEY_PINS-1:0] ksync1;
	logic [KEY_PINS-1:0] ksync2;
	logic [2:0] kcnt;
	logic [NP-1:0] out_val;
	logic [NP-1:0] m_q;
	logic [NP-1:0] m_pp;
	logic [NP-1:0] m_io;
	logic [NP-1:0] m_od;
	logic [NP-1:0] rise;
	logic [31:0] next_prdata;
	logic next_slverr;
	logic wr;
	logic setup;
	logic kany_low;
	logic key_set;
	logic clk_out_on;
	logic flag_clr;

	// Bus strobes; one access cycle, no wait states
	assign setup = i_psel & ~i_penable;
	assign wr = i_psel & i_penable & i_pwrite;
	assign o_pready = 1'b1;
	assign flag_clr = wr && i_paddr == ADDR_AUX && !i_pwdata[AUX_FLAG];

	// Port latches; reset level caught after release
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			latch <= '0;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			latch <= {NP{i_reset_level_high}};
			strap_done <= 1'b1;
		end else if (wr && i_paddr == ADDR_LATCH) begin
			latch <= i_pwdata[NP-1:0];
		end
	end

	// Mode bits, quasi after reset
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			mode_a <= '0;
			mode_b <= '0;
		end else if (wr && i_paddr == ADDR_MODE_A) begin
			mode_a <= i_pwdata[NP-1:0];
		end else if (wr && i_paddr == ADDR_MODE_B) begin
			mode_b <= i_pwdata[NP-1:0];
		end
	end

	// Option, key enable and interrupt enable
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			option <= '0;
			key_en <= '0;
			irq_en <= 1'b0;
		end else if (wr) begin
			if (i_paddr == ADDR_OPTION) begin
				option <= i_pwdata[OPT_WIDTH-1:0];
			end
			if (i_paddr == ADDR_KEY_EN) begin
				key_en <= i_pwdata[KEY_PINS-1:0];
			end
			if (i_paddr == ADDR_AUX) begin
				irq_en <= i_pwdata[AUX_IRQ_EN];
			end
		end
	end

	// Key input synchroniser
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ksync1 <= '1;
			ksync2 <= '1;
		end else begin
			ksync1 <= i_pin_in[KEY_PINS-1:0];
			ksync2 <= ksync1;
		end
	end

	// Any enabled key low; function active while any pin enabled
	assign kany_low = |(key_en & ~ksync2);
	assign key_set = kany_low && kcnt == CLKS_PER_MC;

	// Low-time counter, saturates at one machine cycle
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			kcnt <= '0;
		end else if (!kany_low) begin
			kcnt <= '0;
		end else if (kcnt != CLKS_PER_MC) begin
			kcnt <= kcnt + 3'h1;
		end
	end

	// Sticky flag, set wins over a clear
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			key_event_flag <= 1'b0;
		end else if (key_set) begin
			key_event_flag <= 1'b1;
		end else if (flag_clr) begin
			key_event_flag <= 1'b0;
		end
	end

	assign o_key_irq = key_event_flag & irq_en;

	// Timer toggles and clock divider
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			tog_a <= 1'b0;
			tog_b <= 1'b0;
		end else begin
			if (i_timer_a_ovf) begin
				tog_a <= ~tog_a;
			end
			if (i_timer_b_ovf) begin
				tog_b <= ~tog_b;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	assign clk_out_on = option[OPT_CLK_EN] & ~i_osc_crystal;

	// Value presented at each pin
	always_comb begin
		out_val = latch;
		if (option[OPT_TA_EN]) begin
			out_val[TA_PIN] = tog_a;
		end
		if (option[OPT_TB_EN]) begin
			out_val[TB_PIN] = tog_b;
		end
		if (clk_out_on) begin
			out_val[PIN_CLK_OUT] = div_cnt[1];
		end
	end

	// Mode decode with fixed pins
	always_comb begin
		m_q = ~mode_a & ~mode_b;
		m_pp = ~mode_a & mode_b;
		m_io = mode_a & ~mode_b;
		m_od = mode_a & mode_b;
		m_q[PIN_OD_A] = 1'b0;
		m_pp[PIN_OD_A] = 1'b0;
		m_io[PIN_OD_A] = 1'b0;
		m_od[PIN_OD_A] = 1'b1;
		m_q[PIN_OD_B] = 1'b0;
		m_pp[PIN_OD_B] = 1'b0;
		m_io[PIN_OD_B] = 1'b0;
		m_od[PIN_OD_B] = 1'b1;
		m_q[PIN_RESET] = 1'b0;
		m_pp[PIN_RESET] = 1'b0;
		m_io[PIN_RESET] = 1'b1;
		m_od[PIN_RESET] = 1'b0;
	end

	assign rise = m_q & out_val & ~out_prev;

	// Pull-up staging history
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			out_prev <= '0;
			strong_kick <= '0;
		end else begin
			out_prev <= out_val;
			strong_kick <= rise;
		end
	end

	// Registered pad drivers
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_pull_down <= '0;
			o_strong_pu <= '0;
			o_weak_pu <= '0;
			o_vweak_pu <= '0;
		end else begin
			// Input-only pins drive nothing
			o_pull_down <= (m_q | m_pp | m_od) & ~out_val;
			o_strong_pu <= (m_pp & out_val) | (m_q & (rise | strong_kick));
			o_weak_pu <= m_q & i_pin_in;
			o_vweak_pu <= m_q & out_val;
		end
	end

	// Input threshold select and reset pin
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_schmitt <= '0;
			o_reset_pin_req <= 1'b0;
		end else begin
			for (int p = 0; p < N_PORTS; p++) begin
				o_schmitt[p*PINS_PER_PORT +: PINS_PER_PORT] <=
					{PINS_PER_PORT{option[OPT_SCHMITT_LSB + p]}};
			end
			o_schmitt[PIN_RESET] <= 1'b1;
			o_reset_pin_req <= ~i_reset_pin_disable & i_pin_in[PIN_RESET];
		end
	end

	// Read mux
	always_comb begin
		next_prdata = '0;
		next_slverr = 1'b0;
		unique case (i_paddr)
			ADDR_LATCH: next_prdata[NP-1:0] = latch;
			ADDR_MODE_A: next_prdata[NP-1:0] = mode_a;
			ADDR_MODE_B: next_prdata[NP-1:0] = mode_b;
			ADDR_OPTION: next_prdata[OPT_WIDTH-1:0] = option;
			ADDR_KEY_EN: next_prdata[KEY_PINS-1:0] = key_en;
			ADDR_AUX: begin
				next_prdata[AUX_FLAG] = key_event_flag;
				next_prdata[AUX_IRQ_EN] = irq_en;
			end
			ADDR_PIN_IN: next_prdata[NP-1:0] = i_pin_in;
			default: next_slverr = 1'b1;
		endcase
	end

	// Answer prepared in the setup cycle
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else if (setup) begin
			o_prdata <= i_pwrite ? 32'h0000_0000 : next_prdata;
			o_pslverr <= next_slverr;
		end
	end

	// Checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_key_held;
		kany_low [*5];
	endsequence

	sequence s_quasi_rise0;
		m_q[0] && rise[0];
	endsequence

	sequence s_key_qualified;
		key_set && irq_en && !(wr && i_paddr == ADDR_AUX);
	endsequence

	a_key_set_time:
	assert property (s_key_held |=> key_event_flag)
		else $error("Key flag not set after held low");

	a_key_not_early:
	assert property ($rose(key_event_flag) |-> $past(kany_low, 1) && $past(kany_low, 5))
		else $error("Key flag set too early");

	a_flag_sticky:
	assert property (key_event_flag && !flag_clr |=> key_event_flag)
		else $error("Key flag dropped without clear");

	a_irq_follow:
	assert property (s_key_qualified |=> o_key_irq)
		else $error("Interrupt not raised by key flag");

	a_strong_pulse:
	assert property (s_quasi_rise0 ##1 m_q[0] && out_val[0] |-> o_strong_pu[0] ##1 o_strong_pu[0])
		else $error("Strong pull-up pulse wrong");

	a_push_pull:
	assert property (m_pp[0] |=> o_strong_pu[0] == $past(out_val[0]) && !o_weak_pu[0])
		else $error("Push-pull drive wrong");

	a_open_drain:
	assert property (1'b1 |=> !o_strong_pu[PIN_OD_A] && !o_weak_pu[PIN_OD_A]
		&& !o_vweak_pu[PIN_OD_A] && !o_strong_pu[PIN_OD_B]
		&& !o_weak_pu[PIN_OD_B] && !o_vweak_pu[PIN_OD_B])
		else $error("Open drain pin pulled up");

	a_input_only:
	assert property (m_io[1] |=> !o_pull_down[1] && !o_strong_pu[1] && !o_vweak_pu[1])
		else $error("Input only pin driven");

	a_clkout_rate:
	assert property (clk_out_on [*3] |-> out_val[PIN_CLK_OUT] != $past(out_val[PIN_CLK_OUT], 2))
		else $error("Clock output not divide by four");

	a_mode_reset:
	assert property ($past(i_reset) |-> mode_a == '0 && mode_b == '0)
		else $error("Mode not quasi after reset");

	a_od_no_pullup:
	assert property (m_od[0] |=> !o_strong_pu[0] && !o_weak_pu[0] && !o_vweak_pu[0])
		else $error("Open drain mode pulled up");

	a_vweak_latch:
	assert property (m_q[0] |=> o_vweak_pu[0] == $past(out_val[0]))
		else $error("Very weak pull-up not following latch");

	a_toggle_pin:
	assert property (option[OPT_TA_EN] && i_timer_a_ovf && !(wr && i_paddr == ADDR_OPTION)
		|=> out_val[TA_PIN] != $past(out_val[TA_PIN]))
		else $error("Timer toggle pin did not flip");

	a_clk_crystal:
	assert property (i_osc_crystal |-> out_val[PIN_CLK_OUT] == latch[PIN_CLK_OUT])
		else $error("Clock output active in crystal mode");

	a_key_sync:
	assert property ($fell(ksync2[0]) |-> $past(i_pin_in[0], 2) == 1'b0)
		else $error("Key input not passed through synchroniser");

endmodule

// >>> test/pkw_pad_model.sv
// Pad model: key switches, external pull-ups and floating pins
`timescale 1ns/1ps
module pkw_pad_model (
	// Clock
	input wire logic i_clk,
	// Drivers from the port block
	input wire logic [23:0] i_pull_down,
	input wire logic [23:0] i_strong_pu,
	input wire logic [23:0] i_weak_pu,
	input wire logic [23:0] i_vweak_pu,
	// Switches and board pull-ups
	input wire logic [23:0] i_key_press,
	input wire logic [23:0] i_ext_pu,
	// Sensed levels
	output logic [23:0] o_pin
);
	logic [23:0] drift = 24'h0;

	// Undriven pins wander every cycle
	always @(posedge i_clk) begin
		drift <= ~drift;
	end

	always_comb begin
		for (int i = 0; i < 24; i++) begin
			if (i_pull_down[i] || i_key_press[i])
				o_pin[i] = 1'b0;
			else if (i_strong_pu[i] || i_weak_pu[i] || i_vweak_pu[i] || i_ext_pu[i])
				o_pin[i] = 1'b1;
			else
				o_pin[i] = drift[i];
		end
	end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the port mode and key wake block
`timescale 1ns/1ps
module testbench;
	import pkw_pkg::*;
	localparam logic [23:0] F = 24'hffd3ff;
	localparam logic [23:0] L = 24'h5a5a5a;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, tao = 0;
	logic tbo = 0, rlh = 1, reset_pin_disable = 1, xtal = 0;
	logic [7:0] pa = 0;
	logic [31:0] pwd = 0, prd, rd;
	logic prdy, perr, er, irq, rreq;
	logic [23:0] pin, pd, spu, wpu, vpu, sch, key = 0, epu = 0;
	int err_count = 0, checks = 0;

	pkw_port_block uut (.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
		.o_pslverr(perr), .i_reset_level_high(rlh), .i_reset_pin_disable(reset_pin_disable),
		.i_osc_crystal(xtal), .i_timer_a_ovf(tao), .i_timer_b_ovf(tbo), .i_pin_in(pin),
		.o_pull_down(pd), .o_strong_pu(spu), .o_weak_pu(wpu), .o_vweak_pu(vpu),
		.o_schmitt(sch), .o_key_irq(irq), .o_reset_pin_req(rreq));
	pkw_pad_model pads (.i_clk(clk), .i_pull_down(pd), .i_strong_pu(spu), .i_weak_pu(wpu),
		.i_vweak_pu(vpu), .i_key_press(key), .i_ext_pu(epu), .o_pin(pin));

	initial begin
		forever #20 clk = ~clk;
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask

	task report_and_stop;
		$display("mismatches %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		if (prdy !== 1'b1) begin
			err_count++;
			report_and_stop();
		end
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	task s_reset;
		chk("vweak", F, vpu);
		chk("pulldn", 0, pd);
		apb(0, ADDR_MODE_A, 0);
		chk("mode_a", 0, rd);
		apb(0, ADDR_LATCH, 0);
		chk("latch", 32'hffffff, rd);
		apb(0, 8'h1c, 0);
		chk("slverr", 1, er);
	endtask

	task s_modes;
		logic [1:0] m;
		apb(1, ADDR_LATCH, {8'h0, L});
		for (int i = 1; i <= 4; i++) begin
			m = i[1:0];
			apb(1, ADDR_MODE_A, {32{m[1]}});
			apb(1, ADDR_MODE_B, {32{m[0]}});
			cyc(4);
			chk("strong", (m == 2'h1) ? L & F : 24'h0, spu & F);
			chk("pulldn", (m == 2'h2) ? 24'h0 : ~L & F, pd & F);
			chk("weak", (m == 2'h0) ? L & F : 24'h0, wpu & F);
			chk("vweak", (m == 2'h0) ? L & F : 24'h0, vpu & F);
			chk("od_pins", 4'h1, {spu[11:10], pd[11:10]});
		end
	endtask

	task s_pulse;
		int n;
		apb(1, ADDR_LATCH, 32'h0);
		cyc(4);
		apb(1, ADDR_LATCH, 32'h1);
		n = 0;
		repeat (6) begin
			@(posedge clk);
			n += (spu[0] === 1'b1);
		end
		chk("pulse", STRONG_PU_CLKS, n);
	endtask

	task s_key;
		apb(1, ADDR_KEY_EN, 32'h1);
		apb(1, ADDR_AUX, 32'h2);
		key[0] <= 1'b1;
		cyc(4);
		key[0] <= 1'b0;
		cyc(10);
		chk("irq_short", 0, irq);
		key[0] <= 1'b1;
		cyc(8);
		key[0] <= 1'b0;
		cyc(3);
		chk("irq", 1, irq);
		apb(1, ADDR_AUX, 32'h1);
		chk("irq_mask", 0, irq);
		apb(0, ADDR_AUX, 0);
		chk("flag_held", 1, rd);
		apb(1, ADDR_AUX, 32'h0);
		apb(0, ADDR_AUX, 0);
		chk("flag_clr", 0, rd);
	endtask

	task s_misc;
		apb(1, ADDR_OPTION, 32'hd);
		cyc(2);
		chk("schmitt", 24'hff20ff, sch);
		chk("tog_before", 1, pd[2]);
		tao <= 1'b1;
		@(posedge clk);
		tao <= 1'b0;
		cyc(3);
		chk("tog_after", 0, pd[2]);
		apb(1, ADDR_OPTION, 32'h10);
		cyc(2);
		chk("tog_a_off", 1, pd[2]);
		chk("tog_b_before", 1, pd[3]);
		tbo <= 1'b1;
		@(posedge clk);
		tbo <= 1'b0;
		cyc(3);
		chk("tog_b_after", 0, pd[3]);
	endtask

	task s_clkout;
		logic [7:0] v;
		apb(1, ADDR_OPTION, 32'h20);
		cyc(2);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			v[k] = pd[PIN_CLK_OUT];
		end
		chk("clk_div4", 6'h3f, v[7:2] ^ v[5:0]);
		xtal <= 1'b1;
		cyc(2);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			v[k] = pd[PIN_CLK_OUT];
		end
		chk("clk_xtal", 4'hf, v[3:0]);
		xtal <= 1'b0;
	endtask

	task s_resetpin;
		epu <= 24'h002000;
		reset_pin_disable <= 1'b0;
		cyc(3);
		chk("rst_req_hi", 1, rreq);
		key[PIN_RESET] <= 1'b1;
		cyc(3);
		chk("rst_req_lo", 0, rreq);
		key[PIN_RESET] <= 1'b0;
		reset_pin_disable <= 1'b1;
		cyc(3);
		chk("rst_req_off", 0, rreq);
		epu <= 24'h0;
	endtask

	task s_rerun;
		apb(1, ADDR_MODE_A, 32'hff);
		rlh <= 1'b0;
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(3);
		chk("pd_low", 24'hffdfff, pd);
		chk("vweak_low", 0, vpu);
		apb(0, ADDR_MODE_A, 0);
		chk("mode_a_rst", 0, rd);
		apb(0, ADDR_LATCH, 0);
		chk("latch_low", 0, rd);
	endtask

	initial begin
		cyc(16);
		rst <= 1'b0;
		cyc(3);
		s_reset();
		s_modes();
		s_pulse();
		s_key();
		s_misc();
		s_clkout();
		s_resetpin();
		s_rerun();
		report_and_stop();
	end
endmodule
